// [pkg/dcff_pkg.sv]
// Constants and carrier types for the dual-clock FIFO flag block
package dcff_pkg;
  // Storage depth in words, unit step and half depth
  localparam logic [15:0] DEPTH_W = 16'h0400;
  localparam logic [15:0] ONE_W = 16'h0001;
  localparam logic [15:0] HALF_W = 16'h0200;
  // Offsets after reset (m and n), plain defaults
  localparam logic [15:0] FULL_OFS_RST = 16'h007F;
  localparam logic [15:0] EMPTY_OFS_RST = 16'h007F;
  // Register byte addresses
  localparam logic [7:0] ADR_FULL_OFS = 8'h00;
  localparam logic [7:0] ADR_EMPTY_OFS = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_OCC = 8'h0C;
  // Delay stages on the write pointer path toward the read side
  localparam int WP_STAGES = 2;

  // Flag timing chosen at master reset
  typedef enum logic [0:0] {
    TIM_ASYNC = 1'b0,
    TIM_SYNC = 1'b1
  } dcff_timing_t;

  // Wishbone request and response
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dcff_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } dcff_wb_rsp_t;

  // Software-set offsets
  typedef struct packed {
    logic [15:0] full_ofs;
    logic [15:0] empty_ofs;
  } dcff_cfg_t;

  // Status bits as read back, bit 0 is hf_n
  typedef struct packed {
    logic fall_through_mode;
    logic tsync;
    logic ff_n;
    logic ef_n;
    logic af_n;
    logic ae_n;
    logic hf_n;
  } dcff_stat_t;
endpackage : dcff_pkg

// [rtl/dcff_delay_line.sv]
// Register chain that delays a pointer by a fixed number of stages
`timescale 1ns/1ps
module dcff_delay_line #(
  parameter int STAGES = 2
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic clr_i, // Pointer clear, active high
  input wire logic [15:0] d_i, // Value to delay
  output logic [STAGES*16-1:0] taps_o // Tap k is d_i delayed k+1 cycles
);
  // Whole state of the chain
  typedef struct packed {
    logic [STAGES-1:0][15:0] st;
  } dcff_dl_state_t;

  dcff_dl_state_t s_q; // Registered stages
  dcff_dl_state_t s_d; // Next stages

  // Shift one stage per clock; clear empties the view
  always_comb begin
    s_d = s_q;
    s_d.st[0] = d_i;
    for (int i = 1; i < STAGES; i++) begin
      s_d.st[i] = s_q.st[i-1];
    end
    if (clr_i) begin
      s_d = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Expose each stage
  for (genvar g = 0; g < STAGES; g++) begin : g_tap
    assign taps_o[g*16 +: 16] = s_q.st[g];
  end
endmodule : dcff_delay_line

// [rtl/dcff_wb_regs.sv]
// Wishbone classic slave holding offsets and showing flag status
`timescale 1ns/1ps
module dcff_wb_regs (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, active high
  input wire dcff_pkg::dcff_wb_req_t req_i, // Bus request
  input wire dcff_pkg::dcff_stat_t stat_i, // Flag status
  input wire logic [15:0] occ_i, // Words held
  output dcff_pkg::dcff_wb_rsp_t rsp_o, // Bus answer
  output dcff_pkg::dcff_cfg_t cfg_o // Offsets to the flag logic
);
  // Whole state of the slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    dcff_pkg::dcff_cfg_t cfg;
  } dcff_wb_state_t;

  dcff_wb_state_t s_q; // Registered state
  dcff_wb_state_t s_d; // Next state
  logic hit; // New access this cycle

  // Decode; one wait state, ack drops the cycle after it is given
  always_comb begin
    s_d = s_q;
    hit = req_i.cyc && req_i.stb && !s_q.ack;
    s_d.ack = hit;
    s_d.dat = '0;
    if (hit) begin
      case (req_i.adr)
        dcff_pkg::ADR_FULL_OFS: begin
          s_d.dat = {16'h0000, s_q.cfg.full_ofs};
          if (req_i.we && req_i.sel[0]) s_d.cfg.full_ofs[7:0] = req_i.dat[7:0];
          if (req_i.we && req_i.sel[1]) s_d.cfg.full_ofs[15:8] = req_i.dat[15:8];
        end
        dcff_pkg::ADR_EMPTY_OFS: begin
          s_d.dat = {16'h0000, s_q.cfg.empty_ofs};
          if (req_i.we && req_i.sel[0]) s_d.cfg.empty_ofs[7:0] = req_i.dat[7:0];
          if (req_i.we && req_i.sel[1]) s_d.cfg.empty_ofs[15:8] = req_i.dat[15:8];
        end
        // Read-only views, writes ignored
        dcff_pkg::ADR_STATUS: s_d.dat = 32'(stat_i);
        dcff_pkg::ADR_OCC: s_d.dat = {16'h0000, occ_i};
        // Unmapped: acked, reads zero
        default: s_d.dat = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.ack <= 1'b0;
      s_q.dat <= '0;
      s_q.cfg.full_ofs <= dcff_pkg::FULL_OFS_RST;
      s_q.cfg.empty_ofs <= dcff_pkg::EMPTY_OFS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_o.ack = s_q.ack;
  assign rsp_o.dat = s_q.dat;
  assign cfg_o = s_q.cfg;
endmodule : dcff_wb_regs

// [rtl/dcff_flags.sv]
// Status flag generator for a FIFO with standard and fall-through modes
// Contract
// - Standard: full low when full, blocks writes
// - Standard: full after exactly depth writes
// - Fall-through: input-ready high when no space
// - Fall-through: input-ready high after depth+1 writes
// - Input-ready count includes output register word
// - Full path: flag registered on the write edge itself, one register stage
// - Standard: empty low when nothing stored
// - Output-ready low when first word valid
// - Output-ready high only after true final read
// - Empty two stages, output-ready three stages
// - Standard: almost-full at depth minus m
// - Fall-through: almost-full at depth+1 minus m
// - Almost-full timing is the same in both flag timing modes
// - Standard: almost-empty at n or fewer
// - Fall-through: almost-empty at n+1 or fewer
// - Almost-empty timing follows chosen flag mode in standard mode only
// - Half-full set by write, cleared by read
// - Standard: half-full after depth/2+1 writes
// - Fall-through: half-full after depth/2+2 writes
// - Flag timing mode latched at master reset
// - Writes ignored while full
// - Empty clears two cycles after write
`timescale 1ns/1ps
module dcff_flags (
  input wire logic clk_i, // Clock, 40 MHz
  input wire logic rst_i, // Sync reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic write_en_i, // Write request, active high
  input wire logic read_en_i, // Read request, active high
  input wire logic master_reset_n_i, // Master reset, active low
  input wire logic partial_reset_n_i, // Partial reset, active low
  input wire logic flag_timing_select_i, // Low async, high sync
  input wire logic fall_through_mode_i, // High selects fall-through
  output logic full_flag_n_o, // Full, standard mode
  output logic input_ready_n_o, // Input ready, fall-through mode
  output logic empty_flag_n_o, // Empty, standard mode
  output logic output_ready_n_o, // Output ready, fall-through mode
  output logic almost_full_n_o, // Almost full
  output logic almost_empty_n_o, // Almost empty
  output logic half_full_n_o, // Half full
  output logic write_accept_o, // Write taken this cycle
  output logic read_accept_o // Read taken this cycle
);
  // Whole state of the flag logic
  typedef struct packed {
    logic [15:0] wp; // Words written
    logic [15:0] rp; // Words taken from storage
    logic [15:0] rpo; // Words read out by the user
    logic ov; // Output register holds a word
    logic fall_through_mode; // Latched mode
    dcff_pkg::dcff_timing_t tim; // Latched flag timing
    logic ff_n;
    logic ef_n;
    logic af_n;
    logic ae_n;
    logic hf_n;
  } dcff_state_t;

  dcff_state_t s_q; // Registered state
  dcff_state_t s_d; // Next state
  dcff_pkg::dcff_cfg_t cfg; // Offsets m and n
  dcff_pkg::dcff_stat_t stat; // Status for readback
  dcff_pkg::dcff_wb_req_t wb_req; // Bundled request
  dcff_pkg::dcff_wb_rsp_t wb_rsp; // Bundled answer
  logic [31:0] wp_taps; // Delayed write pointer
  logic [15:0] wp_t0; // One stage late
  logic [15:0] wp_t1; // Two stages late
  logic clr; // Either reset pin low
  logic wr_ok; // Write accepted
  logic rd_ok; // Read accepted
  logic load; // Storage word moves to output register
  logic mem_has; // Read side sees a stored word
  logic [15:0] cap; // Words held when full
  logic [15:0] occ_t; // True occupancy now
  logic [15:0] occ_tn; // True occupancy next
  logic [15:0] occ_rn; // Read-side view next
  logic [15:0] af_thr; // Almost-full level
  logic [15:0] ae_thr; // Almost-empty level
  logic [15:0] hf_thr; // Half-full level

  // Write pointer as the read side sees it
  dcff_delay_line #(
    .STAGES(dcff_pkg::WP_STAGES)
  ) u_wp_line (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(clr),
    .d_i(s_q.wp),
    .taps_o(wp_taps)
  );

  assign wp_t0 = wp_taps[15:0];
  assign wp_t1 = wp_taps[31:16];

  // Register bank on the bus
  assign wb_req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                    sel: wb_sel_i, dat: wb_dat_i};

  dcff_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(wb_req),
    .stat_i(stat),
    .occ_i(occ_t),
    .rsp_o(wb_rsp),
    .cfg_o(cfg)
  );

  assign wb_dat_o = wb_rsp.dat;
  assign wb_ack_o = wb_rsp.ack;

  // Level thresholds, shifted by the output register in fall-through
  always_comb begin
    clr = !master_reset_n_i || !partial_reset_n_i;
    cap = s_q.fall_through_mode ? dcff_pkg::DEPTH_W + dcff_pkg::ONE_W : dcff_pkg::DEPTH_W;
    af_thr = cap - cfg.full_ofs;
    ae_thr = s_q.fall_through_mode ? cfg.empty_ofs + dcff_pkg::ONE_W : cfg.empty_ofs;
    hf_thr = s_q.fall_through_mode ? dcff_pkg::HALF_W + dcff_pkg::ONE_W : dcff_pkg::HALF_W;
    occ_t = s_q.wp - s_q.rpo;
  end

  // Pointer and flag update
  always_comb begin
    s_d = s_q;
    // Flag low means full: further writes dropped
    wr_ok = write_en_i && s_q.ff_n;
    mem_has = (wp_t1 != s_q.rp);
    load = 1'b0;
    if (s_q.fall_through_mode) begin
      // Only a word in the output register can be read
      rd_ok = read_en_i && s_q.ov;
      // Refill the output register without a request
      load = mem_has && (!s_q.ov || rd_ok);
    end else begin
      rd_ok = read_en_i && s_q.ef_n;
    end
    if (wr_ok) s_d.wp = s_q.wp + dcff_pkg::ONE_W;
    if (rd_ok) s_d.rpo = s_q.rpo + dcff_pkg::ONE_W;
    if (s_q.fall_through_mode ? load : rd_ok) s_d.rp = s_q.rp + dcff_pkg::ONE_W;
    if (load) begin
      s_d.ov = 1'b1;
    end else if (rd_ok) begin
      // Last word leaves, old data stays on the outputs
      s_d.ov = 1'b0;
    end
    occ_tn = s_d.wp - s_d.rpo;
    // Write side reads rpo from its own register: one stage, same edge
    s_d.ff_n = !(occ_tn >= cap);
    if (s_q.fall_through_mode) begin
      // Pointer stage, two delay stages, then output register
      s_d.ef_n = !s_d.ov;
    end else begin
      // One delay stage then this flag: two stages
      s_d.ef_n = (wp_t0 != s_d.rp);
    end
    occ_rn = wp_t0 - s_d.rpo;
    if (s_q.tim == dcff_pkg::TIM_SYNC) begin
      // Sync: almost-full and standard almost-empty see their own side's view; fall-through almost-empty sees true occupancy
      s_d.af_n = !(occ_tn >= af_thr);
      s_d.ae_n = s_q.fall_through_mode ? !(occ_tn <= ae_thr) : !(occ_rn <= ae_thr);
    end else begin
      // Async: set by one side, cleared by the other
      s_d.af_n = !(occ_tn >= af_thr);
      s_d.ae_n = !(occ_tn <= ae_thr);
    end
    // Write raises above half, read brings back down
    s_d.hf_n = !(occ_tn > hf_thr);
    if (!master_reset_n_i) begin
      // Modes caught while master reset is held
      s_d.fall_through_mode = fall_through_mode_i;
      s_d.tim = dcff_pkg::dcff_timing_t'(flag_timing_select_i);
    end
    if (clr) begin
      // Empty storage picture
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.rpo = '0;
      s_d.ov = 1'b0;
      s_d.ff_n = 1'b1;
      s_d.ef_n = s_d.fall_through_mode; // Empty in standard, no word ready in fall-through
      s_d.af_n = 1'b1;
      s_d.ae_n = 1'b0;
      s_d.hf_n = 1'b1;
    end
  end

  // State register; modes take constants on bus reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{wp: '0, rp: '0, rpo: '0, ov: 1'b0, fall_through_mode: 1'b0, tim: dcff_pkg::TIM_ASYNC,
               ff_n: 1'b1, ef_n: 1'b0, af_n: 1'b1, ae_n: 1'b0, hf_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Dual-purpose pins; the unused meaning rests inactive high
  always_comb begin
    full_flag_n_o = s_q.fall_through_mode ? 1'b1 : s_q.ff_n;
    input_ready_n_o = s_q.fall_through_mode ? !s_q.ff_n : 1'b1;
    empty_flag_n_o = s_q.fall_through_mode ? 1'b1 : s_q.ef_n;
    output_ready_n_o = s_q.fall_through_mode ? s_q.ef_n : 1'b1;
    almost_full_n_o = s_q.af_n;
    almost_empty_n_o = s_q.ae_n;
    half_full_n_o = s_q.hf_n;
    write_accept_o = wr_ok && !clr;
    read_accept_o = rd_ok && !clr;
    stat = '{fall_through_mode: s_q.fall_through_mode, tsync: s_q.tim, ff_n: s_q.ff_n, ef_n: s_q.ef_n,
             af_n: s_q.af_n, ae_n: s_q.ae_n, hf_n: s_q.hf_n};
  end

  // Checks on the flag behaviour
  property p_full_level;
    @(posedge clk_i) disable iff (rst_i)
    !s_q.fall_through_mode |-> (s_q.ff_n == (occ_t < dcff_pkg::DEPTH_W));
  endproperty
  a_full_level: assert property (p_full_level) else $error("full flag disagrees with occupancy");

  property p_full_count;
    @(posedge clk_i) disable iff (rst_i || clr)
    (!s_q.fall_through_mode && write_accept_o && !read_accept_o && occ_t == dcff_pkg::DEPTH_W - dcff_pkg::ONE_W)
      |=> !full_flag_n_o;
  endproperty
  a_full_count: assert property (p_full_count) else $error("full missed at depth");

  property p_ir_count;
    @(posedge clk_i) disable iff (rst_i || clr)
    (s_q.fall_through_mode && write_accept_o && !read_accept_o && occ_t == dcff_pkg::DEPTH_W)
      |=> input_ready_n_o;
  endproperty
  a_ir_count: assert property (p_ir_count) else $error("input ready missed at depth+1");

  property p_no_overwrite;
    @(posedge clk_i) disable iff (rst_i)
    (write_en_i && !s_q.ff_n && !clr) |=> $stable(s_q.wp);
  endproperty
  a_no_overwrite: assert property (p_no_overwrite) else $error("write taken while full");

  property p_empty_lat;
    @(posedge clk_i) disable iff (rst_i || clr)
    (!s_q.fall_through_mode && !s_q.ef_n && write_accept_o) |-> ##3 empty_flag_n_o;
  endproperty
  a_empty_lat: assert property (p_empty_lat) else $error("empty not cleared two cycles after write");

  property p_first_word;
    @(posedge clk_i) disable iff (rst_i || clr)
    (s_q.fall_through_mode && occ_t == 16'h0000 && write_accept_o) |-> ##4 !output_ready_n_o;
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not shown on third edge");

  property p_last_read;
    @(posedge clk_i) disable iff (rst_i || clr)
    (s_q.fall_through_mode && read_accept_o && !mem_has) |=> output_ready_n_o;
  endproperty
  a_last_read: assert property (p_last_read) else $error("output ready stayed low after last read");

  property p_half_set;
    @(posedge clk_i) disable iff (rst_i || clr)
    (write_accept_o && !read_accept_o && occ_t == hf_thr) |=> !half_full_n_o;
  endproperty
  a_half_set: assert property (p_half_set) else $error("half full not set");

  property p_reset_flags;
    @(posedge clk_i) disable iff (rst_i)
    !partial_reset_n_i |=> (s_q.ff_n && (s_q.ef_n == s_q.fall_through_mode) && s_q.af_n && !s_q.ae_n && s_q.hf_n
      && occ_t == 16'h0000);
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("reset left flags not empty");

  property p_ae_async;
    @(posedge clk_i) disable iff (rst_i || clr)
    (s_q.tim == dcff_pkg::TIM_ASYNC && !s_q.fall_through_mode && $stable(cfg.empty_ofs))
      |-> (s_q.ae_n == (occ_t > cfg.empty_ofs));
  endproperty
  a_ae_async: assert property (p_ae_async) else $error("almost empty disagrees with occupancy");

  // Input-ready counts the output register word too
  property p_ir_level;
    @(posedge clk_i) disable iff (rst_i)
    s_q.fall_through_mode |-> (input_ready_n_o == (occ_t >= dcff_pkg::DEPTH_W + dcff_pkg::ONE_W));
  endproperty
  a_ir_level: assert property (p_ir_level) else $error("input ready disagrees with occupancy");

  // Lagging pointer view never shows a word that is not there
  property p_empty_level;
    @(posedge clk_i) disable iff (rst_i)
    (!s_q.fall_through_mode && occ_t == 16'h0000) |-> !empty_flag_n_o;
  endproperty
  a_empty_level: assert property (p_empty_level) else $error("empty flag high with nothing stored");

  // No word held, so output ready must rest high
  property p_or_idle;
    @(posedge clk_i) disable iff (rst_i)
    (s_q.fall_through_mode && occ_t == 16'h0000) |-> output_ready_n_o;
  endproperty
  a_or_idle: assert property (p_or_idle) else $error("output ready low with nothing held");

  // Almost-full level once a new offset has settled
  property p_af_level;
    @(posedge clk_i) disable iff (rst_i || clr)
    $stable(cfg.full_ofs) |-> (s_q.af_n == (occ_t < af_thr));
  endproperty
  a_af_level: assert property (p_af_level) else $error("almost full disagrees with occupancy");

  // Half-full boundary in standard mode
  property p_hf_std;
    @(posedge clk_i) disable iff (rst_i)
    !s_q.fall_through_mode |-> (s_q.hf_n == (occ_t <= dcff_pkg::HALF_W));
  endproperty
  a_hf_std: assert property (p_hf_std) else $error("half full wrong in standard mode");

  // Half-full boundary moved up by the output word
  property p_hf_fall_through_mode;
    @(posedge clk_i) disable iff (rst_i)
    s_q.fall_through_mode |-> (s_q.hf_n == (occ_t <= dcff_pkg::HALF_W + dcff_pkg::ONE_W));
  endproperty
  a_hf_fall_through_mode: assert property (p_hf_fall_through_mode) else $error("half full wrong in fall-through mode");

  // A read back down to the half-full level hf_thr clears half-full
  property p_half_clr;
    @(posedge clk_i) disable iff (rst_i || clr)
    (read_accept_o && !write_accept_o && occ_t == hf_thr + dcff_pkg::ONE_W) |=> half_full_n_o;
  endproperty
  a_half_clr: assert property (p_half_clr) else $error("half full not cleared by read");

  // An accepted write moves the pointer by exactly one
  property p_wp_step;
    @(posedge clk_i) disable iff (rst_i || clr)
    write_accept_o |=> (s_q.wp == $past(s_q.wp) + dcff_pkg::ONE_W);
  endproperty
  a_wp_step: assert property (p_wp_step) else $error("write pointer did not step by one");

  // Modes only move while master reset is held
  property p_mode_hold;
    @(posedge clk_i) disable iff (rst_i)
    master_reset_n_i |=> ($stable(s_q.fall_through_mode) && $stable(s_q.tim));
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside master reset");
endmodule : dcff_flags

// [dv/dcff_ctrl_model.sv]
// Write-side and read-side controller model that steers the word count
`timescale 1ns/1ps
module dcff_ctrl_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Clear, active high
  input wire logic [15:0] tgt_i, // Word count to reach
  input wire logic push_i, // Keep writing even when full
  input wire logic slow_i, // Request only every other cycle
  input wire logic write_accept_i, // Write taken
  input wire logic read_accept_i, // Read taken
  output logic write_en_o, // Write request
  output logic read_en_o, // Read request
  output logic [15:0] occ_o // Words held as seen here
);
  logic ph_q; // Stall phase
  // Count accepts and steer requests toward the target
  always_ff @(posedge clk_i) begin
    logic [15:0] nxt;
    nxt = occ_o + 16'(write_accept_i) - 16'(read_accept_i);
    if (rst_i) begin
      occ_o <= 16'h0000;
      ph_q <= 1'b0;
      write_en_o <= 1'b0;
      read_en_o <= 1'b0;
    end else begin
      occ_o <= nxt;
      ph_q <= ~ph_q;
      // Decided on the next count so the target is never overshot
      write_en_o <= push_i | ((nxt < tgt_i) & (~slow_i | ph_q));
      read_en_o <= (nxt > tgt_i) & (~slow_i | ph_q);
    end
  end
endmodule : dcff_ctrl_model

// [dv/dcff_flags_bench.sv]
// Self-checking bench for the FIFO flag block
`timescale 1ns/1ps
module dcff_flags_bench;
  logic clk_i = 1'b0; // 40 MHz clock
  logic rst_i = 1'b1; // Sync reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
  logic [7:0] adr = 8'h00; // Bus address
  logic [31:0] wdat = 32'h0000_0000; // Bus write data
  logic [31:0] rdat; // Last read data
  logic mrst_n = 1'b1, prst_n = 1'b1, tsel = 1'b0, fwsel = 1'b0; // Reset and mode pins
  logic push = 1'b0, slow = 1'b0, fw = 1'b0, ts = 1'b0; // Model controls, expected modes
  logic [15:0] tgt = 16'h0000; // Count target
  logic [15:0] m = dcff_pkg::FULL_OFS_RST; // Expected full offset
  logic [15:0] n = dcff_pkg::EMPTY_OFS_RST; // Expected empty offset
  logic [31:0] wb_dat_o;
  logic wb_ack_o, full_flag_n_o, input_ready_n_o, empty_flag_n_o, output_ready_n_o;
  logic almost_full_n_o, almost_empty_n_o, half_full_n_o, write_accept_o, read_accept_o;
  logic wen, ren; // Model requests
  logic [15:0] occ; // Model count
  int n_mismatch = 0;
  int checks = 0;

  always #12.5 clk_i = ~clk_i;

  dcff_flags i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .write_en_i(wen), .read_en_i(ren), .master_reset_n_i(mrst_n), .partial_reset_n_i(prst_n),
    .flag_timing_select_i(tsel), .fall_through_mode_i(fwsel), .full_flag_n_o(full_flag_n_o),
    .input_ready_n_o(input_ready_n_o), .empty_flag_n_o(empty_flag_n_o),
    .output_ready_n_o(output_ready_n_o), .almost_full_n_o(almost_full_n_o),
    .almost_empty_n_o(almost_empty_n_o), .half_full_n_o(half_full_n_o),
    .write_accept_o(write_accept_o), .read_accept_o(read_accept_o));

  dcff_ctrl_model i_ctrl (.clk_i(clk_i), .rst_i(rst_i | ~mrst_n | ~prst_n), .tgt_i(tgt),
    .push_i(push), .slow_i(slow), .write_accept_i(write_accept_o), .read_accept_i(read_accept_o),
    .write_en_o(wen), .read_en_o(ren), .occ_o(occ));

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k == 50) chk("bus ack", 16'h0001, 16'h0000);
  endtask : bus

  // Compare every flag with what the word count implies
  task check_at(input int o);
    int cap;
    logic af, ae, hf;
    cap = int'(dcff_pkg::DEPTH_W) + int'(fw);
    af = !(o >= cap - int'(m));
    ae = !(o <= int'(n) + int'(fw));
    hf = !(o > int'(dcff_pkg::HALF_W) + int'(fw));
    @(negedge clk_i);
    chk("full_flag_n", fw ? 1'b1 : (o != cap), full_flag_n_o);
    chk("input_ready_n", fw ? (o == cap) : 1'b1, input_ready_n_o);
    chk("empty_flag_n", fw ? 1'b1 : (o != 0), empty_flag_n_o);
    chk("output_ready_n", fw ? (o == 0) : 1'b1, output_ready_n_o);
    chk("almost_full_n", af, almost_full_n_o);
    chk("almost_empty_n", ae, almost_empty_n_o);
    chk("half_full_n", hf, half_full_n_o);
    bus(1'b0, dcff_pkg::ADR_OCC, 32'h0000_0000);
    chk("occupancy", o[15:0], rdat[15:0]);
    bus(1'b0, dcff_pkg::ADR_STATUS, 32'h0000_0000);
    chk("status", {11'h000, fw, ts, af, ae, hf}, {11'h000, rdat[6:5], rdat[2:0]});
  endtask : check_at

  // Steer the model to a count and let the flags settle
  task go(input int t);
    int k;
    @(posedge clk_i);
    tgt <= t[15:0];
    for (k = 0; k < 4000 && occ !== t[15:0]; k++) @(posedge clk_i);
    if (k == 4000) chk("count reached", t[15:0], occ);
    repeat (4) @(posedge clk_i);
  endtask : go

  // Latch modes, then move the pins away
  task mreset(input logic f, input logic t);
    @(posedge clk_i);
    tgt <= 16'h0000;
    mrst_n <= 1'b0;
    fwsel <= f;
    tsel <= t;
    repeat (2) @(posedge clk_i);
    mrst_n <= 1'b1;
    fwsel <= ~f;
    tsel <= ~t;
    fw = f;
    ts = t;
    repeat (2) @(posedge clk_i);
    check_at(0);
  endtask : mreset

  // Cycles from the first write to a readable word
  task first_word();
    int d;
    int k;
    @(posedge clk_i);
    tgt <= 16'h0001;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (write_accept_o === 1'b1) break;
    end
    for (d = 0; d < 8; d++) begin
      @(negedge clk_i);
      if (fw ? (output_ready_n_o === 1'b0) : (empty_flag_n_o === 1'b1)) break;
      @(posedge clk_i);
    end
    chk("first word latency", 16'(2 + int'(fw)), 16'(d));
    go(0);
    check_at(0);
  endtask : first_word

  // Climb through every threshold, push at full, then come down
  task walk();
    int p[9];
    int cap;
    int i;
    cap = int'(dcff_pkg::DEPTH_W) + int'(fw);
    p = '{1, int'(n) + int'(fw), int'(n) + int'(fw) + 1, int'(dcff_pkg::HALF_W) + int'(fw),
      int'(dcff_pkg::HALF_W) + int'(fw) + 1, cap - int'(m) - 1, cap - int'(m), cap - 1, cap};
    for (i = 0; i < 9; i++) begin
      go(p[i]);
      check_at(p[i]);
    end
    @(posedge clk_i);
    push <= 1'b1;
    repeat (4) begin
      @(negedge clk_i);
      chk("write_accept at full", 16'h0000, 16'(write_accept_o));
    end
    @(posedge clk_i);
    push <= 1'b0;
    check_at(cap);
    for (i = 7; i >= 0; i--) begin
      go(p[i]);
      check_at(p[i]);
    end
    go(0);
    check_at(0);
  endtask : walk

  task final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, dcff_pkg::ADR_FULL_OFS, 32'h0000_0000);
    chk("full offset", dcff_pkg::FULL_OFS_RST, rdat[15:0]);
    bus(1'b0, dcff_pkg::ADR_EMPTY_OFS, 32'h0000_0000);
    chk("empty offset", dcff_pkg::EMPTY_OFS_RST, rdat[15:0]);
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped read", 16'h0000, rdat[15:0]);
    bus(1'b1, dcff_pkg::ADR_STATUS, 32'hFFFF_FFFF);
    mreset(1'b0, 1'b0);
    first_word();
    walk();
    go(300);
    @(posedge clk_i);
    prst_n <= 1'b0;
    tgt <= 16'h0000;
    @(posedge clk_i);
    prst_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    check_at(0);
    bus(1'b1, dcff_pkg::ADR_FULL_OFS, 32'h0000_0010);
    bus(1'b1, dcff_pkg::ADR_EMPTY_OFS, 32'h0000_0020);
    m = 16'h0010;
    n = 16'h0020;
    bus(1'b0, dcff_pkg::ADR_EMPTY_OFS, 32'h0000_0000);
    chk("empty offset", n, rdat[15:0]);
    mreset(1'b1, 1'b1);
    first_word();
    slow <= 1'b1;
    walk();
    mreset(1'b0, 1'b1);
    walk();
    final_report();
  end

  // Watchdog cuts a hang short
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    $display("watchdog expired");
    final_report();
  end
endmodule : dcff_flags_bench
